// File: include/ssp_defs.vh
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// ----------------------------------------
// Instruction opcodes (byte 1)
// ----------------------------------------
`define SSP_OP_ACCESS   8'hac
`define SSP_OP_POLL     8'hf0
`define SSP_OP_LD_EXT   8'h4d
`define SSP_OP_LD_FHI   8'h48
`define SSP_OP_LD_FLO   8'h40
`define SSP_OP_LD_EPG   8'hc1
`define SSP_OP_RD_FHI   8'h28
`define SSP_OP_RD_FLO   8'h20
`define SSP_OP_RD_EE    8'ha0
`define SSP_OP_WR_FPG   8'h4c
`define SSP_OP_WR_EPG   8'hc2
`define SSP_OP_WR_EE    8'hc0

// ----------------------------------------
// Second byte of the access group
// ----------------------------------------
`define SSP_B2_ENABLE   8'h53
`define SSP_B2_ERASE    8'h80

// ----------------------------------------
// Values and timing
// ----------------------------------------
`define SSP_ERASED      8'hff
// Sized to the timer so the cycle products need no truncation
`define SSP_CLK_MHZ     21'hc8
`define SSP_T_FLASH_US  21'h1194
`define SSP_T_EE_US     21'h2328
`define SSP_T_ERASE_US  21'h2328
`define SSP_TMR_W       21
`define SSP_LAST_BIT    3'h7
`define SSP_RESP_IDX    2'h2
`define SSP_LAST_IDX    2'h3

`endif

// File: hdl/ssp_sync.v
`timescale 1ns/1ps
`default_nettype none

module ssp_sync #(
  parameter N = 3
) (
  input  wire         i_clk_sys,
  input  wire         i_rst,
  input  wire [N-1:0] i_d,
  output wire [N-1:0] o_q
);

  reg [N-1:0] meta_r;
  reg [N-1:0] q_r;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_bit
      always @(posedge i_clk_sys) begin
        if (i_rst) begin
          meta_r[g] <= 1'b1;
          q_r[g]    <= 1'b1;
        end else begin
          meta_r[g] <= i_d[g];
          q_r[g]    <= meta_r[g];
        end
      end
    end
  endgenerate

  assign o_q = q_r;

endmodule // ssp_sync

`default_nettype wire

// File: hdl/ssp_fifo.v
`timescale 1ns/1ps
`default_nettype none

module ssp_fifo #(
  parameter W     = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire         i_clk_sys,
  input  wire         i_rst,
  input  wire         i_valid,
  output wire         o_ready,
  input  wire [W-1:0] i_data,
  output wire         o_valid,
  input  wire         i_ready,
  output wire [W-1:0] o_data
);

  reg [W-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;

  wire wr = i_valid & o_ready;
  wire rd = o_valid & i_ready;

  assign o_ready = (cnt_r != DEPTH[AW:0]);
  assign o_valid = (cnt_r != {(AW+1){1'b0}});
  assign o_data  = mem_r[rp_r];

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        mem_r[wp_r] <= i_data;
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (rd)
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (wr & ~rd)
        cnt_r <= cnt_r + 1'b1;
      else if (rd & ~wr)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule // ssp_fifo

`default_nettype wire

// File: hdl/ssp_port.v
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.vh"

// What this block does
// - Programming works only while the chip reset pin is low.
// - Program and erase instructions are ignored until programming is enabled.
// - MOSI bits are sampled on rising SCK edges.
// - MISO bits change on falling SCK edges.
// - EEPROM writes erase the target byte inside the timed operation.
// - Chip erase sets all flash and EEPROM bytes to all ones.
// - Second enable byte echoes while the third arrives; retry on mismatch.
// - Flash page buffer loads one byte each; low before high.
// - Flash page commit uses upper address; busy for 4.5 ms.
// - EEPROM byte write carries address and data; busy for 9.0 ms.
// - EEPROM page commit alters only loaded bytes.
// - Read instructions return the addressed byte on MISO.
// - Reset pin high leaves programming mode.
// - Chip erase is AC 80 00 00.
// - Page buffer loads are 48 high and 40 low, address, data.
// - Extended address load is 4D 00 addr 00.
// - EEPROM page buffer load is C1 00 addr data.
// - Flash reads are 28 high and 20 low, data in byte four.
// - Status bit 0 set means an operation is pending.
// - Flash page commit is 4C msb lsb 00.
// - EEPROM page commit is C2; byte write is C0 with data.
module ssp_port #(
  parameter FL_AW          = 14,
  parameter PG_AW          = 6,
  parameter EE_AW          = 10,
  parameter EP_AW          = 2,
  parameter FIFO_DEPTH     = 8,
  parameter FIFO_AW        = 3,
  parameter [`SSP_TMR_W-1:0] FLASH_WAIT_CYC = `SSP_T_FLASH_US * `SSP_CLK_MHZ,
  parameter [`SSP_TMR_W-1:0] EE_WAIT_CYC    = `SSP_T_EE_US * `SSP_CLK_MHZ,
  parameter [`SSP_TMR_W-1:0] ERASE_WAIT_CYC = `SSP_T_ERASE_US * `SSP_CLK_MHZ
) (
  input  wire i_clk_sys,
  input  wire i_rst,
  input  wire i_reset_pin_n,
  input  wire i_sck,
  input  wire i_mosi,
  output wire o_miso,
  output wire o_miso_oe,
  output wire o_prog_mode,
  output wire o_busy,
  output wire o_rx_overrun
);

  localparam FL_WORDS = 1 << FL_AW;
  localparam PG_WORDS = 1 << PG_AW;
  localparam EE_BYTES = 1 << EE_AW;
  localparam EP_BYTES = 1 << EP_AW;

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // ----------------------------------------
  // Query opcodes are answered at the pins
  // ----------------------------------------
  function is_query;
    input [7:0] op;
    begin
      is_query = (op == `SSP_OP_POLL) || (op == `SSP_OP_RD_FHI) ||
                 (op == `SSP_OP_RD_FLO) || (op == `SSP_OP_RD_EE);
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers and SCK edges
  // ----------------------------------------
  wire [2:0] pin_q;

  ssp_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_d       ({i_reset_pin_n, i_sck, i_mosi}),
    .o_q       (pin_q)
  );

  wire sel    = ~pin_q[2];
  wire sck_q  = pin_q[1];
  wire mosi_q = pin_q[0];

  reg  sck_d_r;
  // Edges only count while selected, so a pin that idles high does no harm
  wire sck_rise = sel & sck_q & ~sck_d_r;
  wire sck_fall = sel & ~sck_q & sck_d_r;

  always @(posedge i_clk_sys) begin
    if (i_rst)
      sck_d_r <= 1'b0;
    else
      sck_d_r <= sck_q;
  end

  // ----------------------------------------
  // Memories and executor state
  // ----------------------------------------
  reg [7:0] fl_hi_r [0:FL_WORDS-1];
  reg [7:0] fl_lo_r [0:FL_WORDS-1];
  reg [7:0] pb_hi_r [0:PG_WORDS-1];
  reg [7:0] pb_lo_r [0:PG_WORDS-1];
  reg [7:0] ee_r    [0:EE_BYTES-1];
  reg [7:0] eb_r    [0:EP_BYTES-1];
  reg [EP_BYTES-1:0] eb_mask_r;

  reg                  st_r;
  reg [`SSP_TMR_W-1:0] tmr_r;
  reg                  prog_en_r;
  reg [7:0]            ext_r;
  reg [1:0]            eidx_r;
  reg [7:0]            e1_r;
  reg [7:0]            e2_r;
  reg [7:0]            e3_r;

  wire       q_valid;
  wire [7:0] q_data;
  wire       q_pop = (st_r == ST_IDLE);

  // ----------------------------------------
  // Front end: shift in, answer, forward
  // ----------------------------------------
  reg [2:0] bit_r;
  reg [1:0] idx_r;
  reg [7:0] rx_r;
  reg [7:0] tx_r;
  reg       miso_r;
  reg [7:0] b1_r;
  reg [7:0] b2_r;
  reg       fwd_r;
  reg       ovr_r;
  reg [7:0] resp;

  wire [7:0] rx_nxt    = {rx_r[6:0], mosi_q};
  wire       byte_done = sck_rise & (bit_r == `SSP_LAST_BIT);
  wire       fwd_nxt   = (idx_r == 2'h0) ? ~is_query(rx_nxt) : fwd_r;
  wire       push      = byte_done & fwd_nxt;
  wire       q_ready;

  wire [23:0]      rd_fa_full = {ext_r, b2_r, rx_nxt};
  wire [FL_AW-1:0] rd_fa      = rd_fa_full[FL_AW-1:0];
  wire [15:0]      rd_ea_full = {b2_r, rx_nxt};
  wire [EE_AW-1:0] rd_ea      = rd_ea_full[EE_AW-1:0];

  // Busy covers queued and half-gathered instructions, not only the timer
  wire busy = (st_r != ST_IDLE) | q_valid | (eidx_r != 2'h0);

  always @* begin
    case (b1_r)
      `SSP_OP_RD_FHI: resp = fl_hi_r[rd_fa];
      `SSP_OP_RD_FLO: resp = fl_lo_r[rd_fa];
      `SSP_OP_RD_EE:  resp = ee_r[rd_ea];
      `SSP_OP_POLL:   resp = {7'h00, busy};
      default:        resp = rx_nxt;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_rst | ~sel) begin
      bit_r  <= 3'h0;
      idx_r  <= 2'h0;
      rx_r   <= 8'h00;
      tx_r   <= 8'h00;
      miso_r <= 1'b0;
      b1_r   <= 8'h00;
      b2_r   <= 8'h00;
      fwd_r  <= 1'b0;
      ovr_r  <= 1'b0;
    end else begin
      if (sck_rise) begin
        rx_r  <= rx_nxt;
        bit_r <= bit_r + 3'h1;
      end
      if (byte_done) begin
        idx_r <= idx_r + 2'h1;
        fwd_r <= fwd_nxt;
        if (idx_r == 2'h0)
          b1_r <= rx_nxt;
        if (idx_r == 2'h1)
          b2_r <= rx_nxt;
        // Byte four carries the answer; other bytes echo the last one in
        if (idx_r == `SSP_RESP_IDX)
          tx_r <= resp;
        else
          tx_r <= rx_nxt;
      end else if (sck_fall) begin
        miso_r <= tx_r[7];
        tx_r   <= {tx_r[6:0], 1'b0};
      end
      // The link cannot be stalled, so a full queue drops the byte
      if (push & ~q_ready)
        ovr_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Byte queue between link and executor
  // ----------------------------------------
  ssp_fifo #(
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst | ~sel),
    .i_valid   (push),
    .o_ready   (q_ready),
    .i_data    (rx_nxt),
    .o_valid   (q_valid),
    .i_ready   (q_pop),
    .o_data    (q_data)
  );

  // ----------------------------------------
  // Executor
  // ----------------------------------------
  wire exec = q_valid & q_pop & (eidx_r == `SSP_LAST_IDX);

  wire [23:0]        fa_full = {ext_r, e2_r, e3_r};
  wire [FL_AW-1:0]   fa      = fa_full[FL_AW-1:0];
  wire [15:0]        ea_full = {e2_r, e3_r};
  wire [EE_AW-1:0]   ea      = ea_full[EE_AW-1:0];
  wire [PG_AW-1:0]   pb_idx  = e3_r[PG_AW-1:0];
  wire [EP_AW-1:0]   eb_idx  = e3_r[EP_AW-1:0];

  integer k;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r      <= ST_IDLE;
      tmr_r     <= {`SSP_TMR_W{1'b0}};
      prog_en_r <= 1'b0;
      ext_r     <= 8'h00;
      eidx_r    <= 2'h0;
      e1_r      <= 8'h00;
      e2_r      <= 8'h00;
      e3_r      <= 8'h00;
      eb_mask_r <= {EP_BYTES{1'b0}};
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (q_valid) begin
            eidx_r <= eidx_r + 2'h1;
            if (eidx_r == 2'h0)
              e1_r <= q_data;
            if (eidx_r == 2'h1)
              e2_r <= q_data;
            if (eidx_r == 2'h2)
              e3_r <= q_data;
          end
          if (exec) begin
            if (e1_r == `SSP_OP_ACCESS && e2_r == `SSP_B2_ENABLE) begin
              prog_en_r <= 1'b1;
            end else if (prog_en_r) begin
              case (e1_r)
                `SSP_OP_ACCESS: begin
                  if (e2_r == `SSP_B2_ERASE) begin
                    for (k = 0; k < FL_WORDS; k = k + 1) begin
                      fl_hi_r[k] <= `SSP_ERASED;
                      fl_lo_r[k] <= `SSP_ERASED;
                    end
                    for (k = 0; k < EE_BYTES; k = k + 1)
                      ee_r[k] <= `SSP_ERASED;
                    tmr_r <= ERASE_WAIT_CYC;
                    st_r  <= ST_WAIT;
                  end
                end
                `SSP_OP_LD_EXT: begin
                  ext_r <= e3_r;
                end
                `SSP_OP_LD_FHI: begin
                  pb_hi_r[pb_idx] <= q_data;
                end
                `SSP_OP_LD_FLO: begin
                  pb_lo_r[pb_idx] <= q_data;
                end
                `SSP_OP_WR_FPG: begin
                  for (k = 0; k < PG_WORDS; k = k + 1) begin
                    fl_hi_r[{fa[FL_AW-1:PG_AW], k[PG_AW-1:0]}] <= pb_hi_r[k];
                    fl_lo_r[{fa[FL_AW-1:PG_AW], k[PG_AW-1:0]}] <= pb_lo_r[k];
                  end
                  tmr_r <= FLASH_WAIT_CYC;
                  st_r  <= ST_WAIT;
                end
                `SSP_OP_WR_EE: begin
                  // Overwrite is the erase-then-write of the byte
                  ee_r[ea] <= q_data;
                  tmr_r    <= EE_WAIT_CYC;
                  st_r     <= ST_WAIT;
                end
                `SSP_OP_LD_EPG: begin
                  eb_r[eb_idx]      <= q_data;
                  eb_mask_r[eb_idx] <= 1'b1;
                end
                `SSP_OP_WR_EPG: begin
                  for (k = 0; k < EP_BYTES; k = k + 1) begin
                    if (eb_mask_r[k])
                      ee_r[{ea[EE_AW-1:EP_AW], k[EP_AW-1:0]}] <= eb_r[k];
                  end
                  eb_mask_r <= {EP_BYTES{1'b0}};
                  tmr_r     <= EE_WAIT_CYC;
                  st_r      <= ST_WAIT;
                end
                default: begin
                end
              endcase
            end
          end
        end
        ST_WAIT: begin
          // Queue keeps filling here; the link side sees busy on poll
          tmr_r <= tmr_r - 1'b1;
          if (tmr_r <= {{(`SSP_TMR_W-1){1'b0}}, 1'b1})
            st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
      // Leaving the mode drops the enable and any half instruction
      if (~sel) begin
        prog_en_r <= 1'b0;
        eidx_r    <= 2'h0;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  reg oe_r;

  always @(posedge i_clk_sys) begin
    if (i_rst)
      oe_r <= 1'b0;
    else
      oe_r <= sel;
  end

  assign o_miso       = miso_r;
  assign o_miso_oe    = oe_r;
  assign o_prog_mode  = prog_en_r;
  assign o_busy       = busy;
  assign o_rx_overrun = ovr_r;

endmodule // ssp_port

`default_nettype wire

// File: dv/ssp_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_port_mon (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reset_pin_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic o_prog_mode,
  input wire logic o_busy,
  input wire logic o_rx_overrun
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Pin level held past the synchroniser
  // ----------------------------------------
  sequence s_pin_hi; i_reset_pin_n [*6]; endsequence
  sequence s_pin_lo; !i_reset_pin_n [*6]; endsequence
  property p_oe_off; s_pin_hi |-> !o_miso_oe; endproperty
  property p_oe_on; s_pin_lo |-> o_miso_oe; endproperty
  property p_mode_exit; s_pin_hi |-> !o_prog_mode; endproperty
  property p_ovr_clear; s_pin_hi |-> !o_rx_overrun; endproperty
  property p_mode_pin; $rose(o_prog_mode) |-> o_miso_oe; endproperty
  property p_mode_frame; $rose(o_prog_mode) |-> $past(i_sck, 4); endproperty
  property p_miso_fall;
    $changed(o_miso) && o_miso_oe && $past(o_miso_oe) |-> !i_sck;
  endproperty
  property p_miso_hold;
    i_sck && $past(i_sck, 5) && o_miso_oe && $past(o_miso_oe) |-> $stable(o_miso);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso driven while pin high");
  a_oe_on: assert property (p_oe_on) else $error("miso not driven while pin low");
  a_mode_exit: assert property (p_mode_exit) else $error("mode kept after pin high");
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun kept after pin high");
  a_mode_pin: assert property (p_mode_pin) else $error("mode entered while pin high");
  a_mode_frame: assert property (p_mode_frame) else $error("mode entered off frame end");
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved while sck high");
  a_miso_hold: assert property (p_miso_hold) else $error("miso unstable in high phase");
endmodule // ssp_port_mon

bind ssp_port ssp_port_mon u_mon (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_reset_pin_n(i_reset_pin_n), .i_sck(i_sck), .i_mosi(i_mosi), .o_miso(o_miso),
  .o_miso_oe(o_miso_oe), .o_prog_mode(o_prog_mode), .o_busy(o_busy),
  .o_rx_overrun(o_rx_overrun));
`default_nettype wire

// File: dv/ssp_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_prog_model #(
  parameter int HALF   = 8,
  parameter int SETTLE = 40
) (
  input  wire logic i_clk_sys,
  input  wire logic i_miso,
  output var logic  o_sck,
  output var logic  o_mosi,
  output var logic  o_reset_pin_n
);
  // Pin starts high with SCK low so the first drop acts as the reset pulse
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_reset_pin_n = 1'b1;
  end
  // Settle time stands in for the long power-up wait
  task automatic pin(input logic v);
    o_reset_pin_n = v;
    repeat (SETTLE) @(negedge i_clk_sys);
  endtask
  // ----------------------------------------
  // One four-byte instruction, MSB first
  // ----------------------------------------
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      repeat (HALF / 2) @(negedge i_clk_sys);
      o_mosi = tx[i];
      repeat (HALF / 2) @(negedge i_clk_sys);
      rx[i] = i_miso;
      o_sck = 1'b1;
      repeat (HALF) @(negedge i_clk_sys);
      o_sck = 1'b0;
    end
    // Idle line carries no stale bit
    o_mosi = ~o_mosi;
  endtask
endmodule // ssp_prog_model
`default_nettype wire

// File: dv/ssp_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_port_bench;
  logic        i_clk_sys;
  logic        i_rst;
  wire logic   sck;
  wire logic   mosi;
  wire logic   pin_n;
  wire logic   miso;
  wire logic   oe;
  wire logic   pm;
  wire logic   busy;
  wire logic   ovr;
  logic [31:0] rx;
  int          n_errors = 0;
  int          checks = 0;

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  // Erase kept long so the queue can be overfilled behind it
  ssp_port #(.FLASH_WAIT_CYC(21'd50), .EE_WAIT_CYC(21'd50), .ERASE_WAIT_CYC(21'd3000)) DUT (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reset_pin_n(pin_n), .i_sck(sck),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .o_prog_mode(pm), .o_busy(busy),
    .o_rx_overrun(ovr));
  ssp_prog_model PRG (.i_clk_sys(i_clk_sys), .i_miso(miso), .o_sck(sck), .o_mosi(mosi),
    .o_reset_pin_n(pin_n));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin
      @(negedge i_clk_sys);
      k++;
    end
    if (k >= 20000) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [31:0] tx, input logic [7:0] exp);
    PRG.xfer(tx, rx);
    check(rx[7:0], exp);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_locked;
    PRG.pin(1'b0);
    PRG.xfer(32'hac80_0000, rx);
    repeat (40) @(negedge i_clk_sys);
    check(busy, 1'b0);
    check(pm, 1'b0);
    $display("locked erase test done");
  endtask
  task automatic t_enable;
    PRG.xfer(32'hac53_0000, rx);
    wait_idle();
    check(rx[15:8], 8'h53);
    check(pm, 1'b1);
    check(oe, 1'b1);
    $display("enable test done");
  endtask
  task automatic t_erase;
    PRG.xfer(32'hac80_0000, rx);
    PRG.xfer(32'hf000_0000, rx);
    check(rx[0], 1'b1);
    for (int i = 0; i < 3; i++)
      PRG.xfer(32'hc000_2011, rx);
    check(ovr, 1'b1);
    PRG.pin(1'b1);
    check({pm, oe, ovr}, 3'h0);
    wait_idle();
    PRG.pin(1'b0);
    t_enable();
    rd(32'h2000_0000, 8'hff);
    rd(32'h2800_0000, 8'hff);
    rd(32'ha000_0003, 8'hff);
    $display("erase test done");
  endtask
  task automatic t_flash;
    PRG.xfer(32'h4d00_0000, rx);
    PRG.xfer(32'h4000_0534, rx);
    PRG.xfer(32'h4800_0512, rx);
    PRG.xfer(32'h4c00_0000, rx);
    wait_idle();
    PRG.xfer(32'hf000_0000, rx);
    check(rx[7:0], 8'h00);
    rd(32'h2000_0500, 8'h34);
    rd(32'h2800_0500, 8'h12);
    $display("flash page test done");
  endtask
  task automatic t_eeprom;
    PRG.xfer(32'hc000_03a5, rx);
    wait_idle();
    PRG.xfer(32'hc000_035a, rx);
    wait_idle();
    rd(32'ha000_0300, 8'h5a);
    PRG.xfer(32'hc100_013c, rx);
    PRG.xfer(32'hc200_0400, rx);
    wait_idle();
    rd(32'ha000_0500, 8'h3c);
    rd(32'ha000_0400, 8'hff);
    rd(32'ha000_0300, 8'h5a);
    $display("eeprom test done");
  endtask

  initial begin
    i_rst = 1'b1;
    repeat (10) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    t_locked();
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    PRG.pin(1'b1);
    check({pm, oe}, 2'h0);
    wrap_up();
  end
endmodule // ssp_port_bench
`default_nettype wire
